// file: desc_decode.sv
`timescale 1ns/1ns
module desc_decode (
   input  wire logic [31:0] i_dw0,
   input  wire logic [31:0] i_dw1,
   input  wire logic [31:0] i_dw2,
   input  wire logic [31:0] i_dw3,
   desc_if.dec              d
);
   // ======================================================
   // field extraction
   assign d.valid  = i_dw0[hs_desc_pkg::V_BIT];
   assign d.req    = i_dw0[hs_desc_pkg::REQ_LSB +: 15];
   assign d.maxpkt = i_dw0[hs_desc_pkg::MAXP_LSB +: 11];
   assign d.mult   = i_dw0[hs_desc_pkg::MULT_LSB +: 2];
   // endpoint split over two words
   assign d.ep     = {i_dw1[hs_desc_pkg::EPHI_LSB +: 3],
                      i_dw0[hs_desc_pkg::EP0_BIT]};
   assign d.faddr  = i_dw1[hs_desc_pkg::FADDR_LSB +: 7];
   assign d.pid    = i_dw1[hs_desc_pkg::PID_LSB +: 2];
   assign d.kind   = i_dw1[hs_desc_pkg::KIND_LSB +: 2];
   assign d.split  = i_dw1[hs_desc_pkg::SPLIT_BIT];
   assign d.base   = i_dw2[hs_desc_pkg::BASE_LSB +: 16];
   assign d.rl     = i_dw2[hs_desc_pkg::RL_LSB +: 4];
   assign d.moved  = i_dw3[hs_desc_pkg::MOVED_LSB +: 15];
   assign d.nak    = i_dw3[hs_desc_pkg::NAK_LSB +: 4];
endmodule

// file: desc_if.sv
`timescale 1ns/1ns
interface desc_if;
   logic        valid;
   logic [14:0] req;
   logic [10:0] maxpkt;
   logic [1:0]  mult;
   logic [3:0]  ep;
   logic [6:0]  faddr;
   logic [1:0]  pid;
   logic [1:0]  kind;
   logic        split;
   logic [15:0] base;
   logic [3:0]  rl;
   logic [14:0] moved;
   logic [3:0]  nak;
   modport dec (output valid, req, maxpkt, mult, ep, faddr, pid, kind,
                split, base, rl, moved, nak);
   modport eng (input valid, req, maxpkt, mult, ep, faddr, pid, kind,
                split, base, rl, moved, nak);
endinterface

// file: hs_async_descriptor_exec.sv
`timescale 1ns/1ns
module hs_async_descriptor_exec (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // token request to the host port
   output logic             o_tok_valid,
   input  wire logic        i_tok_ready,
   output logic      [1:0]  o_tok_pid,
   output logic      [1:0]  o_tok_kind,
   output logic      [6:0]  o_tok_faddr,
   output logic      [3:0]  o_tok_ep,
   output logic             o_tok_split,
   output logic      [10:0] o_tok_maxpkt,
   // handshake result of the transaction
   input  wire logic        i_hs_valid,
   input  wire logic [2:0]  i_hs_code,
   input  wire logic [10:0] i_hs_bytes,
   // received payload from the endpoint
   input  wire logic        i_in_valid,
   input  wire logic [63:0] i_in_data,
   output logic             o_in_ready,
   // payload memory write side
   output logic             o_mem_valid,
   input  wire logic        i_mem_ready,
   output logic      [15:0] o_mem_addr,
   output logic      [63:0] o_mem_data,
   output logic             o_busy
);

   typedef struct packed {
      hs_desc_pkg::st_t  st;
      logic [3:0][31:0]  dw;
      logic [1:0]        pkt;
      logic [15:0]       off;
      logic [31:0]       rdata;
   } eng_t;

   eng_t        s_r;
   eng_t        s_nxt;
   logic [1:0]  rst_sync_r;
   logic        rst_n;
   logic        fifo_rvalid;
   logic        pop;
   logic [14:0] moved_sum;
   logic [1:0]  pkt_inc;
   logic        last_pkt;
   logic        done_ack;
   logic [3:0]  nak_dec;
   logic [2:0]  reg_sel;
   desc_if      d ();

   // ======================================================
   // reset release
   // async assertion, release aligned to the clock
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ======================================================
   // address decode
   // word index of a descriptor register, or 3'h4 if none
   function automatic logic [2:0] dw_sel(input logic [7:0] a);
      unique case (a)
         hs_desc_pkg::OFF_DW0: dw_sel = 3'h0;
         hs_desc_pkg::OFF_DW1: dw_sel = 3'h1;
         hs_desc_pkg::OFF_DW2: dw_sel = 3'h2;
         hs_desc_pkg::OFF_DW3: dw_sel = 3'h3;
         default:              dw_sel = 3'h4;
      endcase
   endfunction
   // decoded once, so the word index can be sliced
   assign reg_sel = dw_sel(i_addr);

   // ======================================================
   // descriptor field view
   desc_decode u_dec (
      .i_dw0 (s_r.dw[0]),
      .i_dw1 (s_r.dw[1]),
      .i_dw2 (s_r.dw[2]),
      .i_dw3 (s_r.dw[3]),
      .d     (d)
   );

   // ======================================================
   // payload buffer
   // back-pressure reaches the endpoint through o_in_ready
   sync_fifo #(
      .W (hs_desc_pkg::FIFO_W),
      .D (hs_desc_pkg::FIFO_D)
   ) u_fifo (
      .i_clk    (i_ref_clk),
      .i_rst_n  (rst_n),
      .i_wvalid (i_in_valid),
      .o_wready (o_in_ready),
      .i_wdata  (i_in_data),
      .o_rvalid (fifo_rvalid),
      .i_rready (i_mem_ready),
      .o_rdata  (o_mem_data)
   );
   assign o_mem_valid = fifo_rvalid;
   assign pop         = fifo_rvalid && i_mem_ready;
   // base is already a ram address, one unit per 8-byte word
   assign o_mem_addr  = d.base + s_r.off;

   // ======================================================
   // token fields straight from the descriptor words, token valid from the state
   assign o_tok_valid  = (s_r.st == hs_desc_pkg::ST_TOKEN);
   assign o_tok_pid    = d.pid;
   assign o_tok_kind   = d.kind;
   assign o_tok_faddr  = d.faddr;
   assign o_tok_ep     = d.ep;
   assign o_tok_split  = d.split;
   assign o_tok_maxpkt = d.maxpkt;
   assign o_busy       = (s_r.st != hs_desc_pkg::ST_IDLE);
   assign o_rdata      = s_r.rdata;

   // ======================================================
   // handshake arithmetic
   assign moved_sum = d.moved + i_hs_bytes;
   assign pkt_inc   = s_r.pkt + 2'h1;
   // burst count 00 matches when the packet count wraps, so it ends at the fourth packet
   assign last_pkt  = (pkt_inc == d.mult);
   assign done_ack  = last_pkt || (moved_sum >= d.req) ||
                      (i_hs_bytes < d.maxpkt);
   assign nak_dec   = d.nak - 4'h1;

   // ======================================================
   // engine next state
   always_comb begin
      s_nxt       = s_r;
      s_nxt.rdata = 32'h0000_0000;
      if (pop) begin
         s_nxt.off = s_r.off + 16'h0001;
      end
      unique case (s_r.st)
         hs_desc_pkg::ST_IDLE: begin
            if (d.valid) begin
               s_nxt.st  = hs_desc_pkg::ST_TOKEN;
               s_nxt.pkt = 2'h0;
               s_nxt.off = hs_desc_pkg::OFF_RST;
            end
         end
         hs_desc_pkg::ST_TOKEN: begin
            if (i_tok_ready) begin
               s_nxt.st = hs_desc_pkg::ST_WAIT;
            end
         end
         hs_desc_pkg::ST_WAIT: begin
            if (i_hs_valid) begin
               s_nxt.st = hs_desc_pkg::ST_TOKEN;
               case (i_hs_code)
                  hs_desc_pkg::HS_ACK,
                  hs_desc_pkg::HS_NYET: begin
                     // total kept live between burst packets
                     s_nxt.dw[3][hs_desc_pkg::MOVED_LSB +: 15] =
                        moved_sum;
                     s_nxt.dw[3][hs_desc_pkg::NAK_LSB +: 4] =
                        d.rl;
                     if (i_hs_code == hs_desc_pkg::HS_NYET &&
                         d.pid == hs_desc_pkg::PID_OUT) begin
                        // probe readiness before the next OUT
                        s_nxt.dw[1][hs_desc_pkg::PID_LSB +: 2] =
                           hs_desc_pkg::PID_PING;
                     end
                     if (d.pid == hs_desc_pkg::PID_PING &&
                         i_hs_code == hs_desc_pkg::HS_ACK) begin
                        // ping answered: resume data, no packet used
                        s_nxt.dw[1][hs_desc_pkg::PID_LSB +: 2] =
                           hs_desc_pkg::PID_OUT;
                     end else begin
                        s_nxt.pkt = pkt_inc;
                        if (done_ack) begin
                           s_nxt.dw[0][hs_desc_pkg::V_BIT] = 1'b0;
                           s_nxt.st = hs_desc_pkg::ST_IDLE;
                        end
                     end
                  end
                  hs_desc_pkg::HS_NAK: begin
                     // zero reload: budget untouched, retry forever
                     if (d.rl != 4'h0) begin
                        s_nxt.dw[3][hs_desc_pkg::NAK_LSB +: 4] =
                           nak_dec;
                        if (nak_dec == 4'h0) begin
                           s_nxt.dw[0][hs_desc_pkg::V_BIT] = 1'b0;
                           s_nxt.st = hs_desc_pkg::ST_IDLE;
                        end
                     end
                  end
                  default: begin
                     // stall or transaction error is fatal
                     s_nxt.dw[0][hs_desc_pkg::V_BIT] = 1'b0;
                     s_nxt.st = hs_desc_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            s_nxt.st = hs_desc_pkg::ST_IDLE;
         end
      endcase
      // software write lands last, so its set of the pending bit
      // wins over a hardware clear in the same cycle
      if (i_wr && reg_sel != 3'h4) begin
         s_nxt.dw[reg_sel[1:0]] = i_wdata;
      end
      // read data stands only in the cycle after the strobe
      if (i_rd) begin
         if (reg_sel != 3'h4) begin
            s_nxt.rdata = s_r.dw[reg_sel[1:0]];
         end else if (i_addr == hs_desc_pkg::OFF_STAT) begin
            s_nxt.rdata = {24'h0000_00, s_r.pkt, fifo_rvalid,
                           o_in_ready, 1'b0, s_r.st};
         end
      end
   end

   // ======================================================
   // state register
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r.st    <= hs_desc_pkg::ST_IDLE;
         s_r.dw    <= {4{hs_desc_pkg::DW_RST}};
         s_r.pkt   <= 2'h0;
         s_r.off   <= hs_desc_pkg::OFF_RST;
         s_r.rdata <= 32'h0000_0000;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// file: hs_async_descriptor_exec_properties.sv
`timescale 1ns/1ns
module hs_exec_chk (
   input wire logic        i_ref_clk,
   input wire logic        i_rst_n,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        o_tok_valid,
   input wire logic        i_tok_ready,
   input wire logic [1:0]  o_tok_pid,
   input wire logic [6:0]  o_tok_faddr,
   input wire logic [3:0]  o_tok_ep,
   input wire logic        i_hs_valid,
   input wire logic [2:0]  i_hs_code,
   input wire logic        o_in_ready,
   input wire logic        o_mem_valid,
   input wire logic        i_mem_ready,
   input wire logic [15:0] o_mem_addr,
   input wire logic [63:0] o_mem_data,
   input wire logic        o_busy
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // ======================================================
   // register port and token handshake
   rdata_idle_a: assert property (
      !$past(i_rd) |-> o_rdata == 32'h0000_0000)
      else $error("read data not zero outside answer cycle");
   tok_hold_a: assert property (
      o_tok_valid && !i_tok_ready |=> o_tok_valid && $stable(o_tok_pid)
      && $stable(o_tok_faddr) && $stable(o_tok_ep))
      else $error("token request dropped or changed before taken");
   tok_wait_a: assert property (
      o_tok_valid && i_tok_ready |=> !o_tok_valid && o_busy)
      else $error("no wait for result after token");
   tok_busy_a: assert property (o_tok_valid |-> o_busy)
      else $error("token request while idle");
   launch_tok_a: assert property (
      i_wr && i_addr == hs_desc_pkg::OFF_DW0 && i_wdata[0] && !o_busy
      |-> ##[1:2] o_tok_valid)
      else $error("launch did not raise a token");
   hs_next_a: assert property (
      i_hs_valid && o_busy && !o_tok_valid && !i_wr
      |=> o_tok_valid || !o_busy)
      else $error("result neither retried nor retired");
   stall_end_a: assert property (
      i_hs_valid && i_hs_code == hs_desc_pkg::HS_STALL && o_busy
      && !o_tok_valid |=> !o_busy)
      else $error("stall did not retire descriptor");
   // ======================================================
   // payload buffer
   pop_addr_a: assert property (
      o_mem_valid && i_mem_ready && !i_wr
      |=> o_mem_addr == $past(o_mem_addr) + 16'h0001)
      else $error("memory address not stepped by one word");
   mem_hold_a: assert property (
      o_mem_valid && !i_mem_ready && !i_wr |=> o_mem_valid
      && $stable(o_mem_data) && $stable(o_mem_addr))
      else $error("memory word changed while stalled");
   full_data_a: assert property (!o_in_ready |-> o_mem_valid)
      else $error("buffer refuses while empty");
   // main scenarios reached
   cover property (i_hs_valid && i_hs_code == hs_desc_pkg::HS_NAK);
   cover property (!o_in_ready);
   cover property (o_tok_valid && o_tok_pid == hs_desc_pkg::PID_PING);
   cover property (i_hs_valid && i_hs_code == hs_desc_pkg::HS_STALL);
endmodule
bind hs_async_descriptor_exec hs_exec_chk u_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_tok_valid(o_tok_valid), .i_tok_ready(i_tok_ready),
   .o_tok_pid(o_tok_pid), .o_tok_faddr(o_tok_faddr), .o_tok_ep(o_tok_ep),
   .i_hs_valid(i_hs_valid), .i_hs_code(i_hs_code),
   .o_in_ready(o_in_ready), .o_mem_valid(o_mem_valid),
   .i_mem_ready(i_mem_ready), .o_mem_addr(o_mem_addr),
   .o_mem_data(o_mem_data), .o_busy(o_busy));

// file: hs_async_descriptor_exec_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
   end \
end
module hs_async_descriptor_exec_tb_top;
   localparam logic [6:0]  FADDR = 7'h5A;
   localparam logic [3:0]  EP    = 4'hB;
   localparam logic [18:0] CPU_A = 19'h0_1400;
   localparam logic [15:0] BASE  = 16'((CPU_A - 19'h0_0400) >> 3);
   logic        ref_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        mem_ready = 1'b1, exp_split;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic        tok_valid, tok_ready, tok_split, hs_valid, in_valid;
   logic        in_ready, mem_valid, busy;
   logic [1:0]  tok_pid, tok_kind, exp_kind;
   logic [6:0]  tok_faddr;
   logic [3:0]  tok_ep, lat = 4'h0;
   logic [10:0] tok_maxpkt, hs_bytes, rsp_bytes = 11'h040;
   logic [2:0]  hs_code;
   logic [11:0] codes = 12'h000;
   logic [15:0] mem_addr;
   logic [63:0] in_data, mem_data;
   logic [1:0]  toks[$];
   int          error_cnt = 0, n_compared = 0;
   always #10 ref_clk = ~ref_clk;
   // ======================================================
   // design and far-side endpoint
   hs_async_descriptor_exec i_dut (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_tok_valid(tok_valid), .i_tok_ready(tok_ready),
      .o_tok_pid(tok_pid), .o_tok_kind(tok_kind), .o_tok_faddr(tok_faddr),
      .o_tok_ep(tok_ep), .o_tok_split(tok_split), .o_tok_maxpkt(tok_maxpkt),
      .i_hs_valid(hs_valid), .i_hs_code(hs_code), .i_hs_bytes(hs_bytes),
      .i_in_valid(in_valid), .i_in_data(in_data), .o_in_ready(in_ready),
      .o_mem_valid(mem_valid), .i_mem_ready(mem_ready),
      .o_mem_addr(mem_addr), .o_mem_data(mem_data), .o_busy(busy));
   usb_ep_model i_ep (
      .i_clk(ref_clk), .i_busy(busy), .i_tok_valid(tok_valid),
      .i_tok_pid(tok_pid), .i_codes(codes), .i_bytes(rsp_bytes),
      .i_lat(lat), .i_in_ready(in_ready), .o_tok_ready(tok_ready),
      .o_hs_valid(hs_valid), .o_hs_code(hs_code), .o_hs_bytes(hs_bytes),
      .o_in_valid(in_valid), .o_in_data(in_data));
   // every taken token is logged by pid and its other fields judged mid-cycle
   always @(negedge ref_clk) begin
      if (tok_valid === 1'b1 && tok_ready === 1'b1) begin
         toks.push_back(tok_pid);
         `CHK("tok_faddr", FADDR, tok_faddr)
         `CHK("tok_ep", EP, tok_ep)
         `CHK("tok_kind", exp_kind, tok_kind)
         `CHK("tok_split", exp_split, tok_split)
         `CHK("tok_maxpkt", 11'h040, tok_maxpkt)
      end
   end
   // ======================================================
   // bus and descriptor helpers
   function automatic logic [31:0] w0(input logic [1:0] m,
                                      input logic [10:0] mp, input logic v);
      return {EP[0], m, mp, 15'h5000, 2'h0, v};
   endfunction
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e,
                          input string nm);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      @(negedge ref_clk);
      `CHK(nm, e, rdata)
      @(posedge ref_clk);
   endtask
   // budget equals reload, reserved bits zero, burst count never zero
   task automatic start(input logic [1:0] pid, kind, input logic sp,
                        input logic [1:0] m, input logic [3:0] rl);
      toks = {};
      exp_kind  = kind;
      exp_split = sp;
      wr_reg(hs_desc_pkg::OFF_DW3, {9'h000, rl, 19'h0_0000});
      wr_reg(hs_desc_pkg::OFF_DW2, {3'h0, rl, 1'b0, BASE, 8'h00});
      wr_reg(hs_desc_pkg::OFF_DW1, {17'h0_0000, sp, kind, pid, FADDR,
                                    EP[3:1]});
      wr_reg(hs_desc_pkg::OFF_DW0, w0(m, 11'h040, 1'b1));
   endtask
   // bounded wait for retire, then realign to the rising edge
   task automatic finish_desc(input logic [1:0] m, input logic [31:0] dw3);
      int i;
      @(negedge ref_clk);
      for (i = 0; i < 900 && busy !== 1'b0; i++) @(negedge ref_clk);
      `CHK("retired", 1'b0, busy)
      @(posedge ref_clk);
      chk_reg(hs_desc_pkg::OFF_DW0, w0(m, 11'h040, 1'b0), "dw0_done");
      chk_reg(hs_desc_pkg::OFF_DW3, dw3, "dw3_done");
   endtask
   // ======================================================
   // scenarios
   task automatic s_reset();
      int i;
      for (i = 0; i < 4; i++) chk_reg(8'(4 * i), 32'h0000_0000, "dw_rst");
      chk_reg(hs_desc_pkg::OFF_STAT, 32'h0000_0011, "stat_rst");
      wr_reg(8'h14, 32'hFFFF_FFFF);
      chk_reg(8'h14, 32'h0000_0000, "unmapped");
   endtask
   task automatic s_burst();
      logic [1:0] p[3];
      int         i;
      p = '{hs_desc_pkg::PID_OUT, hs_desc_pkg::PID_IN, hs_desc_pkg::PID_SETUP};
      for (i = 0; i < 3; i++) begin
         start(p[i], i[0] ? 2'h0 : 2'h2, i[0], 2'h2, 4'h3);
         finish_desc(2'h2, 32'h0018_0080);
         `CHK("burst_pkts", 2, toks.size())
         `CHK("burst_pid", p[i], toks[0])
      end
   endtask
   task automatic s_nak();
      codes = {hs_desc_pkg::HS_NAK, hs_desc_pkg::HS_NAK, hs_desc_pkg::HS_ACK,
               hs_desc_pkg::HS_NAK};
      lat = 4'h3;
      start(hs_desc_pkg::PID_OUT, 2'h2, 1'b0, 2'h3, 4'h2);
      finish_desc(2'h3, 32'h0000_0040);
      `CHK("nak_tokens", 4, toks.size())
      lat = 4'h0;
      codes = {hs_desc_pkg::HS_ACK, {3{hs_desc_pkg::HS_NAK}}};
      start(hs_desc_pkg::PID_OUT, 2'h2, 1'b0, 2'h1, 4'h0);
      finish_desc(2'h1, 32'h0000_0040);
      `CHK("nak0_tokens", 4, toks.size())
      // a stall is fatal: one token, counts untouched
      codes = {4{hs_desc_pkg::HS_STALL}};
      start(hs_desc_pkg::PID_OUT, 2'h2, 1'b0, 2'h1, 4'h0);
      finish_desc(2'h1, 32'h0000_0000);
      `CHK("stall_tokens", 1, toks.size())
   endtask
   task automatic s_ping();
      codes = {{3{hs_desc_pkg::HS_ACK}}, hs_desc_pkg::HS_NYET};
      start(hs_desc_pkg::PID_OUT, 2'h0, 1'b1, 2'h2, 4'h3);
      finish_desc(2'h2, 32'h0018_0080);
      `CHK("ping_tokens", 3, toks.size())
      `CHK("ping_pid", hs_desc_pkg::PID_PING, toks[1])
      `CHK("after_ping", hs_desc_pkg::PID_OUT, toks[2])
   endtask
   // receive stalls at the sink until the buffer refuses, then drains
   task automatic s_fifo();
      int i;
      codes = 12'h000;
      rsp_bytes = 11'h048;
      mem_ready <= 1'b0;
      start(hs_desc_pkg::PID_IN, 2'h2, 1'b0, 2'h1, 4'h0);
      for (i = 0; i < 200 && in_ready !== 1'b0; i++) @(negedge ref_clk);
      @(posedge ref_clk);
      chk_reg(hs_desc_pkg::OFF_STAT, 32'h0000_0024, "stat_full");
      mem_ready <= 1'b1;
      for (i = 0; i < 9; i++) begin
         @(negedge ref_clk);
         `CHK("mem_valid", 1'b1, mem_valid)
         `CHK("mem_addr", BASE + 16'(i), mem_addr)
         `CHK("mem_data", 64'(i), mem_data)
         @(posedge ref_clk);
      end
      finish_desc(2'h1, 32'h0000_0048);
   endtask
   // ======================================================
   // run control
   task automatic give_verdict();
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      s_reset();
      s_burst();
      s_nak();
      s_ping();
      s_fifo();
      give_verdict();
   end
   // a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      give_verdict();
   end
endmodule

// file: hs_desc_pkg.sv
package hs_desc_pkg;

   // ======================================================
   // register offsets (byte addresses on the plain port)
   localparam logic [7:0] OFF_DW0  = 8'h00;
   localparam logic [7:0] OFF_DW1  = 8'h04;
   localparam logic [7:0] OFF_DW2  = 8'h08;
   localparam logic [7:0] OFF_DW3  = 8'h0C;
   localparam logic [7:0] OFF_STAT = 8'h10;

   // ======================================================
   // reset values
   localparam logic [31:0] DW_RST  = 32'h0000_0000;
   localparam logic [15:0] OFF_RST = 16'h0000;

   // ======================================================
   // field positions, word 0
   localparam int V_BIT    = 0;
   localparam int REQ_LSB  = 3;   // requested_byte_total [17:3]
   localparam int MAXP_LSB = 18;  // max packet [28:18]
   localparam int MULT_LSB = 29;  // burst_packet_count [30:29]
   localparam int EP0_BIT  = 31;  // endpoint_number[0]
   // word 1 (descriptor bits 63:32)
   localparam int EPHI_LSB  = 0;  // endpoint_number[3:1]
   localparam int FADDR_LSB = 3;  // function_addr [41:35]
   localparam int PID_LSB   = 10; // pid_kind_code [43:42]
   localparam int KIND_LSB  = 12; // transfer_kind_code [45:44]
   localparam int SPLIT_BIT = 14; // divided_hub_flag [46]
   // word 2
   localparam int BASE_LSB = 8;   // payload_ram_base [23:8]
   localparam int RL_LSB   = 25;  // nak_reload_value [28:25]
   // word 3 (descriptor bits 127:96)
   localparam int MOVED_LSB = 0;  // bytes_moved_count [110:96]
   localparam int NAK_LSB   = 19; // nak_retry_budget [118:115]

   // ======================================================
   // codes
   localparam logic [1:0] PID_OUT      = 2'h0;
   localparam logic [1:0] PID_IN       = 2'h1;
   localparam logic [1:0] PID_SETUP    = 2'h2;
   localparam logic [1:0] PID_PING     = 2'h3;
   localparam logic [1:0] KIND_CONTROL = 2'h0;
   localparam logic [1:0] KIND_BULK    = 2'h2;
   localparam logic [2:0] HS_ACK       = 3'h0;
   localparam logic [2:0] HS_NAK       = 3'h1;
   localparam logic [2:0] HS_NYET      = 3'h2;
   localparam logic [2:0] HS_STALL     = 3'h3;
   localparam logic [2:0] HS_ERR       = 3'h4;

   // ======================================================
   // payload memory mapping and buffering
   localparam logic [15:0] RAM_CPU_OFFSET = 16'h0400;
   localparam int          RAM_UNIT_SHIFT = 3; // divide by eight
   localparam int          FIFO_W         = 64;
   localparam int          FIFO_D         = 8;

   // cpu address to payload ram address, for software's use
   function automatic logic [15:0] cpu_to_ram(input logic [18:0] a);
      logic [18:0] d;
      d = a - {3'h0, RAM_CPU_OFFSET};
      return d[18:RAM_UNIT_SHIFT];
   endfunction

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_TOKEN = 3'b010,
      ST_WAIT  = 3'b100
   } st_t;

endpackage

// file: sync_fifo.sv
`timescale 1ns/1ns
module sync_fifo #(
   parameter int W = 64,
   parameter int D = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_wvalid,
   output logic              o_wready,
   input  wire logic [W-1:0] i_wdata,
   output logic              o_rvalid,
   input  wire logic         i_rready,
   output logic [W-1:0]      o_rdata
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         wp;
      logic [AW:0]         rp;
   } fifo_t;

   fifo_t s_r;
   fifo_t s_nxt;
   logic  full;
   logic  empty;

   // ======================================================
   // flags: extra pointer bit tells full from empty
   assign empty    = (s_r.wp == s_r.rp);
   assign full     = (s_r.wp[AW] != s_r.rp[AW]) &&
                     (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
   assign o_wready = !full;
   assign o_rvalid = !empty;
   assign o_rdata  = s_r.mem[s_r.rp[AW-1:0]];

   // pointer and storage update
   always_comb begin
      s_nxt = s_r;
      if (i_wvalid && !full) begin
         s_nxt.mem[s_r.wp[AW-1:0]] = i_wdata;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (i_rready && !empty) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// file: usb_ep_model.sv
`timescale 1ns/1ns
module usb_ep_model (
   input  wire logic        i_clk,
   input  wire logic        i_busy,
   input  wire logic        i_tok_valid,
   input  wire logic [1:0]  i_tok_pid,
   input  wire logic [11:0] i_codes,
   input  wire logic [10:0] i_bytes,
   input  wire logic [3:0]  i_lat,
   input  wire logic        i_in_ready,
   output logic             o_tok_ready,
   output logic             o_hs_valid,
   output logic [2:0]       o_hs_code,
   output logic [10:0]      o_hs_bytes,
   output logic             o_in_valid,
   output logic [63:0]      o_in_data
);
   int   idx;
   int   k;
   logic r;
   // one transaction at a time; answers from the last listed code to the first, which then repeats
   initial begin
      o_tok_ready = 1'b0;
      o_hs_valid  = 1'b0;
      o_in_valid  = 1'b0;
      o_hs_code   = 3'h7;
      o_hs_bytes  = 11'h7FF;
      o_in_data   = '1;
      idx = 0;
      forever begin
         @(posedge i_clk);
         #1;
         if (i_busy !== 1'b1) idx = 0;
         if (i_tok_valid === 1'b1) begin
            repeat (i_lat) begin
               @(posedge i_clk);
               #1;
            end
            o_tok_ready = 1'b1;
            @(posedge i_clk);
            #1;
            o_tok_ready = 1'b0;
            // in payload first, each word held until the buffer takes it
            if (i_tok_pid == hs_desc_pkg::PID_IN)
               for (k = 0; k < (int'(i_bytes) + 7) / 8; k++) begin
                  o_in_valid = 1'b1;
                  o_in_data  = 64'(k);
                  do begin
                     r = i_in_ready;
                     @(posedge i_clk);
                     #1;
                  end while (!r);
               end
            // released lines never keep the last value
            o_in_valid = 1'b0;
            o_in_data  = ~o_in_data;
            o_hs_valid = 1'b1;
            o_hs_code  = i_codes[3*idx +: 3];
            // a ping has no data stage, so it moves no bytes
            o_hs_bytes = (i_tok_pid == hs_desc_pkg::PID_PING) ?
                         11'h000 : i_bytes;
            @(posedge i_clk);
            #1;
            o_hs_valid = 1'b0;
            o_hs_code  = ~o_hs_code;
            o_hs_bytes = ~o_hs_bytes;
            if (idx < 3) idx++;
         end
      end
   end
endmodule
